// >>> hw/tmon_pkg.sv
// ============================================================
// Shared constants of the temperature monitor status block
// ============================================================
package tmon_pkg;

  // ==========================================================
  // Channel layout
  // ==========================================================
  localparam int TMON_NUM_CH = 8;     // Local channel 0, remote channels 1..7
  localparam int TMON_NUM_REMOTE = 7;
  localparam int TMON_CH_W = 3;
  localparam int TMON_DATA_W = 8;
  localparam int TMON_ADDR_W = 8;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] TMON_OFS_FAULT = 8'h46;      // remote_diode_fault_flags
  localparam logic [7:0] TMON_OFS_LOW = 8'h47;        // low_threshold_alarm_flags
  localparam logic [7:0] TMON_OFS_IDEAL_CODE = 8'h4b; // transistor_ideality_code
  localparam logic [7:0] TMON_OFS_IDEAL_SEL = 8'h4c;  // ideality_select_mask
  localparam logic [7:0] TMON_OFS_LIMIT_BASE = 8'h50; // low_limit 0x50..0x57

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [7:0] TMON_FAULT_RST = 8'h00;
  localparam logic [7:0] TMON_LOW_RST = 8'h00;
  localparam logic [7:0] TMON_IDEAL_CODE_RST = 8'h09; // Code of factor 1.008
  localparam logic [7:0] TMON_IDEAL_SEL_RST = 8'h00;  // All channels on default
  localparam logic [7:0] TMON_LIMIT_RST = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TMON_FAULT_RSVD_BIT = 7;
  localparam int TMON_LOW_LOCAL_BIT = 6;
  localparam int TMON_LOW_CH7_BIT = 7;
  localparam int TMON_IDEAL_CODE_W = 5;               // Bits 7:5 are ignored

  // ==========================================================
  // Ideality factor in thousandths
  // ==========================================================
  localparam int TMON_IDEAL_W = 11;
  localparam logic [10:0] TMON_IDEAL_BASE_MILLI = 11'h3e7;    // 0.999
  localparam logic [10:0] TMON_IDEAL_DEFAULT_MILLI = 11'h3f0; // 1.008

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int TMON_CONV_TIMEOUT_CYC = 4096; // Wait for conversion done

  // ==========================================================
  // Measurement sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    TMON_SEQ_CHECK,
    TMON_SEQ_START,
    TMON_SEQ_WAIT
  } tmon_seq_e;

endpackage

// >>> hw/tmon_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Two-stage synchroniser for pin levels
// ============================================================
module tmon_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> hw/tmon_top.sv
`timescale 1ns/1ps
`default_nettype none

module tmon_top #(
  parameter int CONV_TIMEOUT_CYC = tmon_pkg::TMON_CONV_TIMEOUT_CYC,
  parameter int NUM_CH = tmon_pkg::TMON_NUM_CH
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Remote diode pin detectors, bit n-1 for remote channel n
  input wire logic [6:0] remote_diode_anode_in_open_i,
  input wire logic [6:0] remote_diode_cathode_in_open_i,
  input wire logic [6:0] remote_diode_anode_in_at_supply_i,
  // Converter handshake
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  output logic [10:0] conv_ideality_o,
  input wire logic conv_done_i,
  input wire logic [7:0] conv_temp_i,
  // Alarm level output
  output logic alert_low_o
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Bit layout of both status registers is fixed to eight channels
  if (NUM_CH != tmon_pkg::TMON_NUM_CH) begin : g_bad_ch
    $error("tmon_top supports exactly eight channels");
  end
  if (CONV_TIMEOUT_CYC < 2 || CONV_TIMEOUT_CYC > 65535) begin : g_bad_to
    $error("tmon_top conversion timeout out of range");
  end
  // Read mux places the reserved zero above the seven fault bits
  if (tmon_pkg::TMON_FAULT_RSVD_BIT != 7) begin : g_bad_rsvd
    $error("tmon_top reserved fault bit must be the top bit");
  end
  // Local and channel 7 low-alarm bits must not share a position
  if (tmon_pkg::TMON_LOW_LOCAL_BIT == tmon_pkg::TMON_LOW_CH7_BIT) begin : g_bad_map
    $error("tmon_top low-alarm bit map collides");
  end
  // Ideality decode pads a five-bit code to eleven bits
  if (tmon_pkg::TMON_IDEAL_CODE_W != 5) begin : g_bad_code
    $error("tmon_top ideality code must be five bits wide");
  end

  localparam int TO_W = $clog2(CONV_TIMEOUT_CYC + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(CONV_TIMEOUT_CYC - 1);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Position of a channel in the low-alarm register
  function automatic logic [2:0] low_bit_idx(input logic [2:0] ch);
    logic [2:0] idx;
    idx = 3'h0;
    if (ch == 3'h0) begin
      idx = 3'(tmon_pkg::TMON_LOW_LOCAL_BIT);
    end else if (ch == 3'h7) begin
      idx = 3'(tmon_pkg::TMON_LOW_CH7_BIT);
    end else begin
      idx = ch - 3'h1;
    end
    return idx;
  endfunction

  // Position of a remote channel in the fault register
  function automatic logic [2:0] fault_bit_idx(input logic [2:0] ch);
    return ch - 3'h1;
  endfunction

  // Linear decode of the programmed ideality code
  function automatic logic [10:0] ideal_milli(input logic [7:0] code);
    logic [10:0] step;
    step = {6'h00, code[tmon_pkg::TMON_IDEAL_CODE_W-1:0]};
    return tmon_pkg::TMON_IDEAL_BASE_MILLI + step;
  endfunction

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [20:0] pins_sync;
  logic [6:0] anode_open_s;
  logic [6:0] cathode_open_s;
  logic [6:0] anode_supply_s;

  tmon_sync #(
    .WIDTH(21)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({remote_diode_anode_in_at_supply_i,
              remote_diode_cathode_in_open_i,
              remote_diode_anode_in_open_i}),
    .sync_o(pins_sync)
  );

  assign anode_open_s = pins_sync[6:0];
  assign cathode_open_s = pins_sync[13:7];
  assign anode_supply_s = pins_sync[20:14];

  // Fault seen now on each remote channel
  wire [6:0] fault_now = (anode_open_s & cathode_open_s) | anode_supply_s;

  // ==========================================================
  // State
  // ==========================================================
  tmon_pkg::tmon_seq_e state_r;
  tmon_pkg::tmon_seq_e state_nxt;
  logic [2:0] chan_r;
  logic [TO_W-1:0] timer_r;
  logic [6:0] fault_r;
  logic [6:0] fault_nxt;
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  logic [7:0] ideal_code_r;
  logic [7:0] ideal_sel_r;
  logic [7:0] limit_r [0:7];
  logic [7:0] rdata_nxt;

  // ==========================================================
  // Register decode
  // ==========================================================
  wire hit_fault = (reg_addr_i == tmon_pkg::TMON_OFS_FAULT);
  wire hit_low = (reg_addr_i == tmon_pkg::TMON_OFS_LOW);
  wire hit_code = (reg_addr_i == tmon_pkg::TMON_OFS_IDEAL_CODE);
  wire hit_sel = (reg_addr_i == tmon_pkg::TMON_OFS_IDEAL_SEL);
  wire hit_limit = (reg_addr_i[7:3] == tmon_pkg::TMON_OFS_LIMIT_BASE[7:3]);
  wire [2:0] limit_idx = reg_addr_i[2:0];

  wire low_rd_clr = reg_rd_i & hit_low;

  // ==========================================================
  // Sequencer decode
  // ==========================================================
  wire chan_remote = (chan_r != 3'h0);
  wire [2:0] chan_fidx = fault_bit_idx(chan_r);
  wire [2:0] chan_lidx = low_bit_idx(chan_r);
  wire chan_faulted = chan_remote & fault_now[chan_fidx];
  wire [2:0] chan_next = chan_r + 3'h1;
  wire timed_out = (timer_r == TO_LAST);
  wire in_check = (state_r == tmon_pkg::TMON_SEQ_CHECK);
  wire in_start = (state_r == tmon_pkg::TMON_SEQ_START);
  wire in_wait = (state_r == tmon_pkg::TMON_SEQ_WAIT);
  wire conv_end = in_wait & conv_done_i;
  wire skip_chan = in_check & chan_faulted;
  wire temp_below = (conv_temp_i < limit_r[chan_r]);

  // Ideality used by the channel about to be converted
  wire [10:0] ideal_pick = ideal_sel_r[chan_r] ? ideal_milli(ideal_code_r)
                                               : tmon_pkg::TMON_IDEAL_DEFAULT_MILLI;

  // Sequencer next state; a hung converter is abandoned after the timeout
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tmon_pkg::TMON_SEQ_CHECK: begin
        if (!chan_faulted) begin
          state_nxt = tmon_pkg::TMON_SEQ_START;
        end
      end
      tmon_pkg::TMON_SEQ_START: begin
        state_nxt = tmon_pkg::TMON_SEQ_WAIT;
      end
      tmon_pkg::TMON_SEQ_WAIT: begin
        if (conv_done_i || timed_out) begin
          state_nxt = tmon_pkg::TMON_SEQ_CHECK;
        end
      end
      default: begin
        state_nxt = tmon_pkg::TMON_SEQ_CHECK;
      end
    endcase
  end

  // ==========================================================
  // Status flag next values
  // ==========================================================
  // Fault bit: set on skip, re-evaluated at the end of a conversion
  // A fault that appears mid-conversion is caught when that conversion ends
  always_comb begin
    fault_nxt = fault_r;
    if (skip_chan) begin
      fault_nxt[chan_fidx] = 1'b1;
    end else if (conv_end && chan_remote) begin
      fault_nxt[chan_fidx] = fault_now[chan_fidx];
    end
  end

  // Low alarm: read clears, a set in the same cycle wins
  always_comb begin
    low_nxt = low_rd_clr ? 8'h00 : low_r;
    if (conv_end && temp_below) begin
      low_nxt[chan_lidx] = 1'b1;
    end
  end

  // ==========================================================
  // Read data mux
  // ==========================================================
  // Unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit_fault) begin
      rdata_nxt = {1'b0, fault_r};
    end else if (hit_low) begin
      rdata_nxt = low_r;
    end else if (hit_code) begin
      rdata_nxt = ideal_code_r;
    end else if (hit_sel) begin
      rdata_nxt = ideal_sel_r;
    end else if (hit_limit) begin
      rdata_nxt = limit_r[limit_idx];
    end
  end

  // ==========================================================
  // Sequencer registers
  // ==========================================================
  // Channel advances after a skip, a finished or an abandoned conversion
  // An abandoned channel keeps its old flags: a hung converter proves nothing
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= tmon_pkg::TMON_SEQ_CHECK;
      chan_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (skip_chan || conv_end || (in_wait && timed_out)) begin
        chan_r <= chan_next;
      end
    end
  end

  // Conversion watchdog
  // Limitation: a converter slower than the timeout never reports a result
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_r <= '0;
    end else if (in_wait) begin
      timer_r <= timer_r + TO_W'(1);
    end else begin
      timer_r <= '0;
    end
  end

  // Start pulse with channel and ideality frozen for the whole conversion
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_start_o <= 1'b0;
      conv_chan_o <= 3'h0;
      conv_ideality_o <= tmon_pkg::TMON_IDEAL_DEFAULT_MILLI;
    end else begin
      conv_start_o <= in_start;
      if (in_start) begin
        conv_chan_o <= chan_r;
        conv_ideality_o <= ideal_pick;
      end
    end
  end

  // ==========================================================
  // Status registers
  // ==========================================================
  // Alarm output is registered from the next flag value so it tracks them
  // Taking the next value avoids a cycle of lag behind the flags themselves
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_r <= tmon_pkg::TMON_FAULT_RST[6:0];
      low_r <= tmon_pkg::TMON_LOW_RST;
      alert_low_o <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      low_r <= low_nxt;
      alert_low_o <= |low_nxt;
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  // Writes only land here; the sequencer samples them at the next start
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ideal_code_r <= tmon_pkg::TMON_IDEAL_CODE_RST;
      ideal_sel_r <= tmon_pkg::TMON_IDEAL_SEL_RST;
    end else if (reg_wr_i) begin
      if (hit_code) begin
        ideal_code_r <= reg_wdata_i;
      end
      if (hit_sel) begin
        ideal_sel_r <= reg_wdata_i;
      end
    end
  end

  // Low limits, one per channel
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 8; i++) begin
        limit_r[i] <= tmon_pkg::TMON_LIMIT_RST;
      end
    end else if (reg_wr_i && hit_limit) begin
      limit_r[limit_idx] <= reg_wdata_i;
    end
  end

  // Read data valid the cycle after the read strobe only
  // Returning zero otherwise keeps stale flags off the bus
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// >>> tb/tmon_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================================
// Port checker of the status and alarm block
module tmon_top_chk #(
  parameter int CONV_TIMEOUT_CYC = tmon_pkg::TMON_CONV_TIMEOUT_CYC,
  parameter int NUM_CH = tmon_pkg::TMON_NUM_CH
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic [10:0] conv_ideality_o,
  input wire logic conv_done_i,
  input wire logic alert_low_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Read of the low-alarm flags, the only thing that may clear them
  wire logic rd_low = reg_rd_i && reg_addr_i == 8'h47;

  chk_fault_rsvd: assert property (reg_rd_i && reg_addr_i == 8'h46 |=> !reg_rdata_o[7])
    else $error("fault register top bit read as one");
  chk_low_clear: assert property (rd_low && !conv_done_i |=> !alert_low_o)
    else $error("alarm output stayed up after flag read");
  chk_alert_fall: assert property ($fell(alert_low_o) |-> $past(rd_low))
    else $error("alarm output fell without a flag read");
  chk_alert_rise: assert property ($rose(alert_low_o) |-> $past(conv_done_i))
    else $error("alarm output rose without a conversion end");
  chk_alert_flags: assert property (rd_low |=> (reg_rdata_o != 8'h00) == $past(alert_low_o))
    else $error("alarm output disagrees with flags read");
  chk_ideal_range: assert property (conv_start_o |-> conv_ideality_o >= 11'h3e7 &&
    conv_ideality_o <= 11'h406)
    else $error("ideality outside the coded range");
  chk_hold_setup: assert property ($changed(conv_ideality_o) || $changed(conv_chan_o)
    |-> conv_start_o)
    else $error("conversion setup changed between starts");
  chk_start_gap: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("conversion started again too soon");

  // Main scenarios reached
  cover property (rd_low ##1 reg_rdata_o != 8'h00);
  cover property ($rose(alert_low_o));
  cover property (conv_start_o && conv_ideality_o != 11'h3f0);
endmodule

bind tmon_top tmon_top_chk #(.CONV_TIMEOUT_CYC(CONV_TIMEOUT_CYC), .NUM_CH(NUM_CH)) tmon_top_chk_inst (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
  .conv_ideality_o(conv_ideality_o), .conv_done_i(conv_done_i), .alert_low_o(alert_low_o));
`default_nettype wire

// >>> tb/tmon_conv_model.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================================
// Converter model: answers each start after a set latency
module tmon_conv_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic conv_start_i,
  input wire logic [2:0] conv_chan_i,
  input wire logic [63:0] temps_i,
  input wire logic [3:0] lat_i,
  output logic conv_done_o,
  output logic [7:0] conv_temp_o
);
  logic busy_r;
  logic [3:0] cnt_r;

  // Result is only valid with done; otherwise it toggles so stale data never looks good
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      conv_done_o <= 1'b0;
      conv_temp_o <= 8'h00;
    end else begin
      conv_done_o <= 1'b0;
      conv_temp_o <= ~conv_temp_o;
      if (conv_start_i) begin
        busy_r <= 1'b1;
        cnt_r <= lat_i;
      end else if (busy_r && cnt_r <= 4'h1) begin
        busy_r <= 1'b0;
        conv_done_o <= 1'b1;
        conv_temp_o <= temps_i[conv_chan_i*8 +: 8];
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tmon_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================================
// Self-checking bench of the status and alarm block
module tmon_top_bench;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [6:0] anode_open = 7'h00;
  logic [6:0] cathode_open = 7'h00;
  logic [6:0] anode_supply = 7'h00;
  logic [7:0] reg_rdata_o, conv_temp_i, code_v, sel_v, rd_v, low_v, lim, t;
  logic [10:0] conv_ideality_o;
  logic [2:0] conv_chan_o;
  logic conv_start_o, conv_done_i, alert_low_o;
  logic [63:0] temps = {8{8'hff}};
  logic [63:0] tv;
  logic [31:0] rnd;
  logic [6:0] flt_v = 7'h00;
  logic [6:0] as_v;
  logic [3:0] lat = 4'h1;
  logic ich = 1'b0;
  logic fchk = 1'b0;
  int seed = 93;
  int fails = 0;
  int comparisons = 0;

  initial forever #4 sys_clk_i = ~sys_clk_i;

  // Small timeout keeps any stuck conversion short
  tmon_top #(.CONV_TIMEOUT_CYC(16)) tmon_top_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .remote_diode_anode_in_open_i(anode_open),
    .remote_diode_cathode_in_open_i(cathode_open), .remote_diode_anode_in_at_supply_i(anode_supply),
    .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .conv_ideality_o(conv_ideality_o),
    .conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i), .alert_low_o(alert_low_o));
  tmon_conv_model tmon_conv_model_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .conv_start_i(conv_start_o), .conv_chan_i(conv_chan_o), .temps_i(temps), .lat_i(lat),
    .conv_done_o(conv_done_i), .conv_temp_o(conv_temp_i));

  // Expectations
  function automatic logic [10:0] ideal_exp(input logic [2:0] ch);
    return sel_v[ch] ? 11'h3e7 + {6'h00, code_v[4:0]} : 11'h3f0;
  endfunction
  function automatic logic [7:0] low_map(input logic [7:0] m);
    return {m[7], m[0], m[6:1]};
  endfunction

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp11(input string n, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ========================================================
  // Register port and converter watching
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic wait_start(output logic [2:0] ch);
    for (int n = 0; n < 300; n++) begin
      @(posedge sys_clk_i);
      #1;
      if (conv_start_o === 1'b1) begin
        ch = conv_chan_o;
        rnd = $random(seed);
        lat <= {1'b0, rnd[2:0]} + 4'h1;
        if (ich) cmp11("ideality", ideal_exp(ch), conv_ideality_o);
        if (fchk && ch != 3'h0) cmp8("faulted_start", 8'h00, {7'h00, flt_v[ch - 3'h1]});
        return;
      end
    end
    fails++;
    stop_test();
  endtask
  task automatic round();
    logic [2:0] c;
    for (int k = 0; k < 10; k++) begin
      wait_start(c);
      if (c === 3'h0) return;
    end
    fails++;
    stop_test();
  endtask

  // ========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(8'h46, rd_v); cmp8("fault_rst", 8'h00, rd_v);
    rd(8'h47, rd_v); cmp8("low_rst", 8'h00, rd_v);
    rd(8'h4b, rd_v); cmp8("code_rst", 8'h09, rd_v);
    rd(8'h45, rd_v); cmp8("unmapped", 8'h00, rd_v);
    code_v = 8'h09;
    sel_v = 8'h00;
    ich = 1'b1;
    // Ideality: both code ends, upper bits set, then random selections
    for (int i = 0; i < 5; i++) begin
      rnd = $random(seed);
      ich = 1'b0;
      code_v = (i == 0) ? 8'he0 : (i == 1) ? 8'h1f : rnd[7:0];
      sel_v = (i < 2) ? 8'hff : rnd[15:8];
      wr(8'h4b, code_v);
      wr(8'h4c, sel_v);
      round();
      ich = 1'b1;
      round();
      rd(8'h4b, rd_v); cmp8("code_back", code_v, rd_v);
      rd(8'h4c, rd_v); cmp8("sel_back", sel_v, rd_v);
    end
    // Low alarms: first pass sits on the limit boundary, later ones random
    for (int i = 0; i < 4; i++) begin
      low_v = 8'h00;
      for (int c = 0; c < 8; c++) begin
        rnd = $random(seed);
        lim = (i == 0) ? 8'h80 : rnd[7:0];
        t = (i == 0) ? (c[0] ? 8'h80 : 8'h7f) : rnd[15:8];
        wr({5'h0a, c[2:0]}, lim);
        rd({5'h0a, c[2:0]}, rd_v); cmp8("limit_back", lim, rd_v);
        tv[c*8 +: 8] = t;
        low_v[c] = t < lim;
      end
      temps <= tv;
      round();
      round();
      temps <= {8{8'hff}};
      round();
      cmp8("alert_set", {7'h00, |low_v}, {7'h00, alert_low_o});
      rd(8'h47, rd_v); cmp8("low_flags", low_map(low_v), rd_v);
      cmp8("alert_clear", 8'h00, {7'h00, alert_low_o});
      rd(8'h47, rd_v); cmp8("low_cleared", 8'h00, rd_v);
    end
    // Diode faults: open pairs and anode at supply, channels skipped
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      as_v = (i == 0) ? 7'h00 : rnd[22:16] & rnd[30:24];
      @(posedge sys_clk_i);
      anode_open <= rnd[6:0];
      cathode_open <= rnd[14:8];
      anode_supply <= as_v;
      flt_v = (rnd[6:0] & rnd[14:8]) | as_v;
      round();
      fchk = 1'b1;
      round();
      fchk = 1'b0;
      rd(8'h46, rd_v); cmp8("fault_flags", {1'b0, flt_v}, rd_v);
    end
    // Second reset in mid-run with faults still present
    code_v = 8'h09;
    sel_v = 8'h00;
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(8'h46, rd_v); cmp8("fault_rst2", 8'h00, rd_v);
    rd(8'h4b, rd_v); cmp8("code_rst2", 8'h09, rd_v);
    // Faults removed: channels converted again and their bits cleared
    @(posedge sys_clk_i);
    anode_open <= 7'h00;
    cathode_open <= 7'h00;
    anode_supply <= 7'h00;
    round();
    round();
    round();
    rd(8'h46, rd_v); cmp8("fault_gone", 8'h00, rd_v);
    stop_test();
  end
endmodule
`default_nettype wire
